// ===== verilog/dms_sequencer.sv
// Serial-bus slave, geometry registers and mode sequencer of the deflection controller
`timescale 1ns/100ps
`include "dms_regs.svh"
// Function
// [R1] One write is start, address, subaddress, one data byte, stop; no auto-increment.
// [R2] Host sends both functions of a shared register together; don't-care bits ignored.
// [R3] No acknowledge while power-on reset holds, supply below 8.3 V.
// [R4] After power-on reset: standby, start values for control bits, unlock high.
// [R5] Standby cleared enables supply; only vertical output active; unlock stays high.
// [R6] Setting soft-start release is ignored while supply below 8.6 V.
// [R7] Host waits 80 ms after supply enable before releasing soft start.
// [R8] Release set ramps line drive, then boost drive, then enables both loops.
// [R9] In operation unlock output is low while the first loop is locked.
// [R10] In operation register writes reach outputs immediately.
// [R11] Operation ends only by clearing release bit or supply loss.
// [R12] Release cleared ramps boost drive down first, then line drive.
// [R13] Protection floats drives and unlock, blanks continuously, stops loops, keeps registers.
// [R14] Protection logic may clear standby and release bits itself.
// [R15] Protection left by standby write, new release write, or supply below 8.1 V.
// [R16] Standby floats drivers; registers except control bits are lost.
// [R17] Supply dip below 8.6 V runs soft-down, then an internal soft start.
// [R18] Supply below 8.1 V disables all drivers at once and enters standby.
// [R19] Below 8.6 V line, boost and vertical outputs float.
// [R20] Subaddress 03: balance in D6..D3, vertical moire in D2..D0, D7 ignored.
// [R21] Subaddress 05: horizontal moire in D4..D0, applied only when moire not disabled.
// [R22] Device answers write-address byte 1000 1100.
// [R23] Standby is D0, release D1 of subaddress 0d; release clear grounds soft-start node.
// [R24] Writes to undocumented subaddresses are acknowledged with no effect.
module dms_sequencer
   import dms_pkg::*;
#(
   parameter logic [7:0] RAMP_STEPS = `DMS_RAMP_STEPS,
   parameter logic [15:0] RAMP_DIV = `DMS_RAMP_DIV
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Supply comparators, high when the supply is above the level
   input wire logic supply_8v1_i,
   input wire logic supply_8v3_i,
   input wire logic supply_8v6_i,
   // Protection and loop status
   input wire logic protect_trip_i,
   input wire logic loop_locked_i,
   // Serial bus, open drain data
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Drive control
   output dms_pkg::dms_drive_s drive_o,
   output logic [7:0] line_duty_o,
   output logic [7:0] boost_duty_o,
   output logic protect_mode_o,
   output dms_pkg::dms_geom_s geom_o,
   output logic [4:0] horizontal_moire_eff_o,
   output logic [2:0] vertical_moire_eff_o
);
   import dms_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [2:0] v81_s;
      logic [2:0] v83_s;
      logic [2:0] v86_s;
      logic scl_q;
      logic sda_q;
      logic v81_q;
      logic v83_q;
      logic v86_q;
      dms_bus_e bus;
      dms_bus_e after_ack;
      logic [2:0] bit_cnt;
      logic [7:0] shifter;
      logic [1:0] byte_idx;
      logic [7:0] sub;
      logic ack_drive;
      dms_mode_e mode;
      logic protect;
      logic standby;
      logic release_bit;
      logic [15:0] div_cnt;
      logic [7:0] line_duty;
      logic [7:0] boost_duty;
      dms_geom_s geom;
   } dms_state_s;

   dms_state_s st_ff;
   dms_state_s nxt_st;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic tick;
   logic wr_strobe;
   logic [7:0] wdata;

   always_comb begin
      nxt_st = st_ff;
      // Three-stage synchronisers; change accepted once stages two and three agree
      nxt_st.scl_s = {st_ff.scl_s[1:0], scl_i};
      nxt_st.sda_s = {st_ff.sda_s[1:0], sda_i};
      nxt_st.v81_s = {st_ff.v81_s[1:0], supply_8v1_i};
      nxt_st.v83_s = {st_ff.v83_s[1:0], supply_8v3_i};
      nxt_st.v86_s = {st_ff.v86_s[1:0], supply_8v6_i};
      if (st_ff.scl_s[1] == st_ff.scl_s[2]) begin
         nxt_st.scl_q = st_ff.scl_s[2];
      end
      if (st_ff.sda_s[1] == st_ff.sda_s[2]) begin
         nxt_st.sda_q = st_ff.sda_s[2];
      end
      if (st_ff.v81_s[1] == st_ff.v81_s[2]) begin
         nxt_st.v81_q = st_ff.v81_s[2];
      end
      if (st_ff.v83_s[1] == st_ff.v83_s[2]) begin
         nxt_st.v83_q = st_ff.v83_s[2];
      end
      if (st_ff.v86_s[1] == st_ff.v86_s[2]) begin
         nxt_st.v86_q = st_ff.v86_s[2];
      end
      scl_rise = nxt_st.scl_q & ~st_ff.scl_q;
      scl_fall = ~nxt_st.scl_q & st_ff.scl_q;
      start_cond = st_ff.scl_q & nxt_st.scl_q & st_ff.sda_q & ~nxt_st.sda_q;
      stop_cond = st_ff.scl_q & nxt_st.scl_q & ~st_ff.sda_q & nxt_st.sda_q;
      wr_strobe = 1'b0;
      wdata = st_ff.shifter;

      // ----------------------------------------
      // Serial slave
      // ----------------------------------------
      if (start_cond) begin
         nxt_st.bus = DMS_I_ADDR;
         nxt_st.bit_cnt = 3'h0;
         nxt_st.byte_idx = 2'h0;
         nxt_st.ack_drive = 1'b0;
      end else if (stop_cond) begin
         nxt_st.bus = DMS_I_IDLE;
         nxt_st.ack_drive = 1'b0;
      end else begin
         unique case (st_ff.bus)
            DMS_I_IDLE, DMS_I_SKIP: begin
               nxt_st.ack_drive = 1'b0;
            end
            DMS_I_ADDR, DMS_I_SUB, DMS_I_DATA: begin
               if (scl_rise) begin
                  nxt_st.shifter = {st_ff.shifter[6:0], st_ff.sda_q};
                  nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
               end
               if (scl_fall && st_ff.bit_cnt == 3'h0 && st_ff.shifter != 8'h00
                   && st_ff.ack_drive == 1'b0 && st_ff.byte_idx[1] == 1'b1) begin
                  nxt_st.ack_drive = 1'b0;
               end
               if (scl_fall && st_ff.bit_cnt == 3'h0 && st_ff.after_ack == DMS_I_ACK) begin
                  nxt_st.after_ack = DMS_I_IDLE;
                  // Eighth bit done: decide the acknowledge
                  nxt_st.bus = DMS_I_ACK;
                  if (st_ff.bus == DMS_I_ADDR) begin
                     // Only a write to our own address, and never during power-on reset
                     if (st_ff.shifter == {`DMS_SLAVE_ADDR, 1'b0} && st_ff.v83_q) begin // [R22] [R3]
                        nxt_st.ack_drive = 1'b1;
                        nxt_st.after_ack = DMS_I_SUB;
                     end else begin
                        nxt_st.bus = DMS_I_SKIP;
                     end
                  end else if (st_ff.bus == DMS_I_SUB) begin
                     nxt_st.sub = st_ff.shifter;
                     nxt_st.ack_drive = 1'b1;
                     nxt_st.after_ack = DMS_I_DATA;
                  end else begin
                     // Later bytes repeat onto the same subaddress
                     nxt_st.ack_drive = 1'b1;
                     nxt_st.after_ack = DMS_I_DATA; // [R1]
                     wr_strobe = 1'b1;
                  end
               end else if (scl_rise && st_ff.bit_cnt == 3'h7) begin
                  nxt_st.after_ack = DMS_I_ACK;
               end
            end
            DMS_I_ACK: begin
               if (scl_fall) begin
                  nxt_st.ack_drive = 1'b0;
                  nxt_st.bit_cnt = 3'h0;
                  nxt_st.bus = st_ff.after_ack;
                  nxt_st.after_ack = DMS_I_IDLE;
               end
            end
            default: begin
               nxt_st.bus = DMS_I_IDLE;
            end
         endcase
      end

      // ----------------------------------------
      // Register writes
      // ----------------------------------------
      if (wr_strobe) begin
         unique case (st_ff.sub)
            `DMS_SA_HSIZE: nxt_st.geom.horizontal_size = wdata;
            `DMS_SA_CTRL1: nxt_st.geom.control_one = {1'b0, wdata[6:0]};
            `DMS_SA_VERTICAL_POSITION: nxt_st.geom.vertical_position = {wdata[7:1], 1'b0};
            `DMS_SA_VBALMOIRE: begin
               nxt_st.geom.vertical_linearity_balance = wdata[6:3]; // [R20]
               nxt_st.geom.vertical_moire_amount = wdata[2:0]; // [R20]
            end
            `DMS_SA_PIN: nxt_st.geom.pincushion_amount = wdata[5:0];
            `DMS_SA_HORIZONTAL_MOIRE_AMOUNT: nxt_st.geom.horizontal_moire_amount = wdata[4:0]; // [R21]
            `DMS_SA_HORIZONTAL_PHASE_POSITION: nxt_st.geom.horizontal_phase_position = wdata;
            `DMS_SA_VLINEW: begin
               nxt_st.geom.vertical_s_correction = wdata[7:4];
               nxt_st.geom.ew_pin_balance = wdata[3:0];
            end
            `DMS_SA_VAMP: nxt_st.geom.vertical_amplitude = wdata;
            `DMS_SA_CORNER: nxt_st.geom.corner_correction = wdata;
            `DMS_SA_FOCUS: nxt_st.geom.focus_parabola = wdata;
            `DMS_SA_CTRL2: nxt_st.geom.control_two = {wdata[7:2], 1'b0, wdata[0]};
            `DMS_SA_TRAP: nxt_st.geom.trapezium_and_parallelogram = wdata;
            `DMS_SA_POWER: begin
               nxt_st.standby = wdata[`DMS_BIT_STANDBY]; // [R23]
               // A release request below 8.6 V is dropped
               if (st_ff.v86_q || !wdata[`DMS_BIT_RELEASE]) begin // [R6]
                  nxt_st.release_bit = wdata[`DMS_BIT_RELEASE];
               end
               if (st_ff.protect && wdata[`DMS_BIT_RELEASE] && st_ff.v86_q) begin
                  nxt_st.protect = 1'b0; // [R15]
                  nxt_st.mode = DMS_SUPPLY_ON;
               end else if (st_ff.protect && wdata[`DMS_BIT_STANDBY]) begin
                  nxt_st.protect = 1'b0; // [R15]
               end
            end
            default: begin
               // Acknowledged but ignored
               nxt_st.standby = st_ff.standby; // [R24]
            end
         endcase
      end

      // ----------------------------------------
      // Mode sequencer
      // ----------------------------------------
      tick = (st_ff.div_cnt == RAMP_DIV);
      nxt_st.div_cnt = tick ? 16'h0000 : st_ff.div_cnt + 16'h0001;
      unique case (st_ff.mode)
         DMS_POR: begin
            if (st_ff.v83_q) begin
               nxt_st.mode = DMS_STANDBY; // [R4]
               nxt_st.standby = `DMS_RST_STANDBY;
               nxt_st.release_bit = `DMS_RST_RELEASE;
            end
         end
         DMS_STANDBY: begin
            // Register contents do not survive standby
            nxt_st.geom = '0; // [R16]
            if (!nxt_st.standby) begin
               nxt_st.mode = DMS_SUPPLY_ON; // [R5]
            end
         end
         DMS_SUPPLY_ON: begin
            if (nxt_st.standby) begin
               nxt_st.mode = DMS_STANDBY;
            end else if (nxt_st.release_bit && st_ff.v86_q && !st_ff.protect) begin
               nxt_st.mode = DMS_RAMP_LINE; // [R8]
            end
         end
         DMS_RAMP_LINE: begin
            if (!nxt_st.release_bit || !st_ff.v86_q) begin
               nxt_st.mode = DMS_DOWN_BOOST; // [R12] [R17]
            end else if (st_ff.line_duty == RAMP_STEPS) begin
               nxt_st.mode = DMS_RAMP_BOOST; // [R8]
            end else if (tick) begin
               nxt_st.line_duty = st_ff.line_duty + 8'h01;
            end
         end
         DMS_RAMP_BOOST: begin
            if (!nxt_st.release_bit || !st_ff.v86_q) begin
               nxt_st.mode = DMS_DOWN_BOOST; // [R12] [R17]
            end else if (st_ff.boost_duty == RAMP_STEPS) begin
               nxt_st.mode = DMS_RUN; // [R8]
            end else if (tick) begin
               nxt_st.boost_duty = st_ff.boost_duty + 8'h01;
            end
         end
         DMS_RUN: begin
            // Only the release bit or the supply ends operation
            if (!nxt_st.release_bit || !st_ff.v86_q) begin // [R11]
               nxt_st.mode = DMS_DOWN_BOOST; // [R12] [R17]
            end
         end
         DMS_DOWN_BOOST: begin
            if (st_ff.boost_duty == 8'h00) begin
               nxt_st.mode = DMS_DOWN_LINE; // [R12]
            end else if (tick) begin
               nxt_st.boost_duty = st_ff.boost_duty - 8'h01;
            end
         end
         DMS_DOWN_LINE: begin
            if (st_ff.line_duty == 8'h00) begin
               // A dip restarts on its own once the supply is back
               nxt_st.mode = nxt_st.standby ? DMS_STANDBY : DMS_SUPPLY_ON; // [R17]
            end else if (tick) begin
               nxt_st.line_duty = st_ff.line_duty - 8'h01;
            end
         end
      endcase

      // Protection trip overrides sequencing; registers are kept
      if (protect_trip_i) begin
         nxt_st.protect = 1'b1; // [R13]
         nxt_st.standby = 1'b0; // [R14]
         nxt_st.release_bit = 1'b0; // [R14]
         nxt_st.mode = DMS_SUPPLY_ON;
         nxt_st.line_duty = 8'h00;
         nxt_st.boost_duty = 8'h00;
      end
      if (!st_ff.v81_q && st_ff.mode != DMS_POR) begin
         nxt_st.mode = DMS_STANDBY; // [R18] [R15]
         nxt_st.protect = 1'b0;
         nxt_st.standby = 1'b1;
         nxt_st.release_bit = 1'b0;
         nxt_st.line_duty = 8'h00;
         nxt_st.boost_duty = 8'h00;
      end
      if (!st_ff.v83_q && st_ff.mode == DMS_STANDBY && !st_ff.v81_q) begin
         nxt_st.mode = DMS_POR;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_ff <= '0;
         st_ff.mode <= DMS_POR;
         st_ff.bus <= DMS_I_IDLE;
         st_ff.after_ack <= DMS_I_IDLE;
         st_ff.scl_s <= 3'h7;
         st_ff.sda_s <= 3'h7;
         st_ff.scl_q <= 1'b1;
         st_ff.sda_q <= 1'b1;
         st_ff.standby <= `DMS_RST_STANDBY;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   logic running;
   logic drivers_on;
   assign running = (st_ff.mode == DMS_RUN);
   assign drivers_on = st_ff.v86_q && !st_ff.protect && (st_ff.mode != DMS_POR)
                       && (st_ff.mode != DMS_STANDBY) && (st_ff.mode != DMS_SUPPLY_ON); // [R19]
   assign sda_o = 1'b0;
   assign sda_oe_o = st_ff.ack_drive;
   assign drive_o.line_drive_o = drivers_on && (st_ff.line_duty != 8'h00);
   assign drive_o.line_drive_oe = drivers_on; // [R13] [R19]
   assign drive_o.boost_drive_oe = drivers_on; // [R13] [R19]
   assign drive_o.vert_oe = st_ff.v86_q && (st_ff.mode != DMS_POR)
                            && (st_ff.mode != DMS_STANDBY); // [R5] [R19]
   assign drive_o.sync_unlock_o = running ? !loop_locked_i : 1'b1; // [R9] [R4]
   assign drive_o.sync_unlock_oe = !st_ff.protect;
   assign drive_o.clamp_blank_cont = st_ff.protect; // [R13]
   // Loops come up only once both ramps are complete, so unlock tracks lock from then on
   assign drive_o.loops_en = drivers_on && running; // [R8] [R13]
   assign drive_o.soft_start_node_gnd = !st_ff.release_bit; // [R23]
   assign line_duty_o = st_ff.line_duty;
   assign boost_duty_o = st_ff.boost_duty;
   assign protect_mode_o = st_ff.protect;
   assign geom_o = st_ff.geom; // [R10]
   assign horizontal_moire_eff_o = st_ff.geom.control_one[`DMS_BIT_MOIRE_DIS] ? 5'h00
                                   : st_ff.geom.horizontal_moire_amount; // [R21]
   assign vertical_moire_eff_o = st_ff.geom.control_one[`DMS_BIT_MOIRE_DIS] ? 3'h0
                                 : st_ff.geom.vertical_moire_amount;
endmodule

// ===== common/dms_regs.svh
// Register offsets, field positions, start values and timing counts of the mode sequencer
`ifndef DMS_REGS_SVH
`define DMS_REGS_SVH
`define DMS_SLAVE_ADDR 7'h46
`define DMS_SA_HSIZE 8'h00
`define DMS_SA_CTRL1 8'h01
`define DMS_SA_VERTICAL_POSITION 8'h02
`define DMS_SA_VBALMOIRE 8'h03
`define DMS_SA_PIN 8'h04
`define DMS_SA_HORIZONTAL_MOIRE_AMOUNT 8'h05
`define DMS_SA_HORIZONTAL_PHASE_POSITION 8'h06
`define DMS_SA_VLINEW 8'h07
`define DMS_SA_VAMP 8'h08
`define DMS_SA_CORNER 8'h09
`define DMS_SA_FOCUS 8'h0a
`define DMS_SA_CTRL2 8'h0b
`define DMS_SA_TRAP 8'h0c
`define DMS_SA_POWER 8'h0d
`define DMS_BIT_STANDBY 0
`define DMS_BIT_RELEASE 1
`define DMS_BIT_MOIRE_DIS 5
`define DMS_RST_STANDBY 1'b1
`define DMS_RST_RELEASE 1'b0
`define DMS_RAMP_STEPS 8'hff
`define DMS_RAMP_DIV 16'h00c3
`endif

// ===== common/dms_pkg.sv
// Types shared by the deflection mode sequencer
package dms_pkg;
   typedef enum logic [2:0] {
      DMS_POR, DMS_STANDBY, DMS_SUPPLY_ON, DMS_RAMP_LINE, DMS_RAMP_BOOST,
      DMS_RUN, DMS_DOWN_BOOST, DMS_DOWN_LINE
   } dms_mode_e;
   typedef enum logic [2:0] {
      DMS_I_IDLE, DMS_I_ADDR, DMS_I_SUB, DMS_I_DATA, DMS_I_ACK, DMS_I_SKIP
   } dms_bus_e;
   typedef struct packed {
      logic line_drive_o;
      logic line_drive_oe;
      logic boost_drive_oe;
      logic vert_oe;
      logic sync_unlock_o;
      logic sync_unlock_oe;
      logic clamp_blank_cont;
      logic loops_en;
      logic soft_start_node_gnd;
   } dms_drive_s;
   typedef struct packed {
      logic [7:0] horizontal_size;
      logic [7:0] vertical_position;
      logic [3:0] vertical_linearity_balance;
      logic [2:0] vertical_moire_amount;
      logic [5:0] pincushion_amount;
      logic [4:0] horizontal_moire_amount;
      logic [7:0] horizontal_phase_position;
      logic [3:0] vertical_s_correction;
      logic [3:0] ew_pin_balance;
      logic [7:0] vertical_amplitude;
      logic [7:0] corner_correction;
      logic [7:0] focus_parabola;
      logic [7:0] trapezium_and_parallelogram;
      logic [7:0] control_one;
      logic [7:0] control_two;
   } dms_geom_s;
endpackage

// ===== test/dms_sequencer_sva.sv
// Concurrent checks on the ports of the deflection mode sequencer
`timescale 1ns/100ps
module dms_sequencer_sva
   import dms_pkg::*;
#(
   parameter logic [7:0] RAMP_STEPS = 8'hff
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Watched inputs
   input wire logic supply_8v1_i,
   input wire logic supply_8v3_i,
   input wire logic supply_8v6_i,
   input wire logic loop_locked_i,
   // Watched outputs
   input wire logic sda_oe_o,
   input wire dms_pkg::dms_drive_s drive_o,
   input wire logic [7:0] line_duty_o,
   input wire logic [7:0] boost_duty_o,
   input wire logic protect_mode_o,
   input wire dms_pkg::dms_geom_s geom_o,
   input wire logic [4:0] horizontal_moire_eff_o,
   input wire logic [2:0] vertical_moire_eff_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   // Repetition counts leave room for the three-stage input synchronisers
   property p_ack_por;
      (!supply_8v3_i) [*6] |-> !sda_oe_o;
   endproperty
   property p_low_off;
      (!supply_8v1_i) [*6] |-> !(drive_o.line_drive_oe | drive_o.boost_drive_oe | drive_o.vert_oe);
   endproperty
   property p_dip_float;
      (!supply_8v6_i) [*6] |-> !(drive_o.line_drive_oe | drive_o.boost_drive_oe | drive_o.vert_oe);
   endproperty
   property p_boost_order;
      (boost_duty_o != 8'h00) |-> (line_duty_o == RAMP_STEPS);
   endproperty
   property p_node_gnd;
      (line_duty_o > $past(line_duty_o)) |-> !drive_o.soft_start_node_gnd;
   endproperty
   property p_protect;
      protect_mode_o |-> !drive_o.line_drive_oe && !drive_o.boost_drive_oe
         && !drive_o.sync_unlock_oe && drive_o.clamp_blank_cont && !drive_o.loops_en;
   endproperty
   property p_unlock;
      (drive_o.loops_en && $stable(loop_locked_i)) [*4] |-> drive_o.sync_unlock_o == !loop_locked_i;
   endproperty
   property p_horizontal_moire_amount;
      $stable(geom_o) [*2] |-> horizontal_moire_eff_o
         == (geom_o.control_one[5] ? 5'h00 : geom_o.horizontal_moire_amount);
   endproperty
   property p_vertical_moire_amount;
      $stable(geom_o) [*2] |-> vertical_moire_eff_o
         == (geom_o.control_one[5] ? 3'h0 : geom_o.vertical_moire_amount);
   endproperty
   a_ack_por: assert property (p_ack_por) else $error("ack given under low supply");
   a_low_off: assert property (p_low_off) else $error("drivers on below low level");
   a_dip_float: assert property (p_dip_float) else $error("drivers on during dip");
   a_boost_order: assert property (p_boost_order) else $error("boost ramp out of order");
   a_node_gnd: assert property (p_node_gnd) else $error("ramp while node grounded");
   a_protect: assert property (p_protect) else $error("protection outputs wrong");
   a_unlock: assert property (p_unlock) else $error("unlock does not follow lock");
   a_horizontal_moire_amount: assert property (p_horizontal_moire_amount) else $error("horizontal moire gating wrong");
   a_vertical_moire_amount: assert property (p_vertical_moire_amount) else $error("vertical moire gating wrong");
   c_run: cover property ($rose(drive_o.loops_en));
   c_prot: cover property ($rose(protect_mode_o));
   c_ack: cover property ($rose(sda_oe_o));
endmodule

// ===== test/dms_host_model.sv
// Serial bus master standing in for the host microcontroller
`timescale 1ns/100ps
module dms_host_model (
   // Clock
   input wire logic clk_i,
   // Serial bus
   input wire logic sda_oe_i,
   output logic scl_o,
   output logic sda_o
);
   // Quarter bit time, far above the device's synchroniser lag
   localparam int Q = 8;
   logic pull_ff = 1'b0;
   initial scl_o = 1'b1;
   // Pulled up wire: either party pulling low wins
   assign sda_o = ~(pull_ff | sda_oe_i);
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         pull_ff <= ~b[i];
         tick(Q);
         scl_o <= 1'b1;
         tick(2 * Q);
         scl_o <= 1'b0;
         tick(Q);
      end
      pull_ff <= 1'b0;
      tick(Q);
      scl_o <= 1'b1;
      tick(Q);
      ack = ~sda_o;
      tick(Q);
      scl_o <= 1'b0;
      tick(Q);
   endtask
   // Start, address, subaddress, one data byte, stop; ok only if all three acked
   task automatic wr(input logic [7:0] a, s, d, output logic ok);
      logic k0, k1, k2;
      pull_ff <= 1'b1;
      tick(Q);
      scl_o <= 1'b0;
      tick(Q);
      put_byte(a, k0);
      put_byte(s, k1);
      put_byte(d, k2);
      pull_ff <= 1'b1;
      tick(Q);
      scl_o <= 1'b1;
      tick(Q);
      pull_ff <= 1'b0;
      tick(4 * Q);
      ok = k0 & k1 & k2;
   endtask
endmodule

// ===== test/dms_sequencer_test.sv
// Self-checking bench of the deflection mode sequencer
`timescale 1ns/100ps
`define CHK(nm, ex, gt) chk_one(nm, ((ex) === (gt)), 32'(ex), 32'(gt))
module dms_sequencer_test;
   import dms_pkg::*;
   logic clk = 1'b0, srst = 1'b1, s81 = 1'b0, s83 = 1'b0, s86 = 1'b0;
   logic trip = 1'b0, locked = 1'b0, scl, sda, sda_oe, prot, ack;
   dms_drive_s drv;
   dms_geom_s geom;
   logic [7:0] line_duty, boost_duty, d, hp, rnd = 8'h29;
   logic [4:0] hm;
   logic [2:0] vm;
   int n_errors = 0, tests_run = 0, cyc = 0;
   always #10 clk = ~clk;
   dms_sequencer #(.RAMP_STEPS(8'h04), .RAMP_DIV(16'h0002)) dut_u (
      .clk_i(clk), .srst_i(srst), .supply_8v1_i(s81), .supply_8v3_i(s83),
      .supply_8v6_i(s86), .protect_trip_i(trip), .loop_locked_i(locked),
      .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .drive_o(drv),
      .line_duty_o(line_duty), .boost_duty_o(boost_duty), .protect_mode_o(prot),
      .geom_o(geom), .horizontal_moire_eff_o(hm), .vertical_moire_eff_o(vm));
   dms_host_model host_u (.clk_i(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [4:0] exp_hm(input logic [7:0] v, input logic dis);
      return dis ? 5'h00 : v[4:0];
   endfunction
   function automatic logic [2:0] exp_vm(input logic [7:0] v, input logic dis);
      return dis ? 3'h0 : v[2:0];
   endfunction
   task automatic chk_one(input string nm, input bit ok, input logic [31:0] e, g);
      tests_run++;
      if (!ok) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] s, v);
      host_u.wr(8'h8c, s, v, ack);
      tick(8);
   endtask
   // Bounded wait for the loops to reach the wanted state
   task automatic wait_loops(input logic want);
      for (int n = 0; n < 600 && drv.loops_en !== want; n++) tick(1);
      `CHK("loops_en", want, drv.loops_en);
   endtask
   task automatic trip_pulse();
      trip <= 1'b1;
      tick(2);
      trip <= 1'b0;
      tick(8);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      tick(4);
      srst <= 1'b0;
      tick(10);
      host_u.wr(8'h8c, 8'h0d, 8'h00, ack);
      `CHK("ack_por", 1'b0, ack);
      s81 <= 1'b1;
      s83 <= 1'b1;
      s86 <= 1'b1;
      tick(12);
      `CHK("unlock_start", 1'b1, drv.sync_unlock_o);
      `CHK("vert_standby", 1'b0, drv.vert_oe);
      host_u.wr(8'h8e, 8'h0d, 8'h00, ack);
      `CHK("ack_wrong_addr", 1'b0, ack);
      wr(8'h0d, 8'h00);
      `CHK("vert_on", 1'b1, drv.vert_oe);
      `CHK("line_off", 1'b0, drv.line_drive_oe);
      `CHK("unlock_supply", 1'b1, drv.sync_unlock_o);
      s86 <= 1'b0;
      wr(8'h0d, 8'h02);
      `CHK("duty_refused", 8'h00, line_duty);
      `CHK("node_gnd", 1'b1, drv.soft_start_node_gnd);
      s86 <= 1'b1;
      tick(8);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         d = (i == 0) ? 8'hff : rnd;
         wr(8'h01, i[0] ? 8'h20 : 8'h00);
         wr(8'h03, d);
         wr(8'h05, d);
         wr(8'h04, d);
         `CHK("vbal", d[6:3], geom.vertical_linearity_balance);
         `CHK("vertical_moire_amount", d[2:0], geom.vertical_moire_amount);
         `CHK("horizontal_moire_amount", d[4:0], geom.horizontal_moire_amount);
         `CHK("pin", d[5:0], geom.pincushion_amount);
         `CHK("hm_eff", exp_hm(d, i[0]), hm);
         `CHK("vm_eff", exp_vm(d, i[0]), vm);
      end
      host_u.wr(8'h8c, 8'h0e, 8'h5a, ack);
      `CHK("ack_unmapped", 1'b1, ack);
      `CHK("horizontal_moire_amount_kept", d[4:0], geom.horizontal_moire_amount);
      // Host settling delay before release, scaled far down from the real figure
      tick(200);
      wr(8'h0d, 8'h02);
      wait_loops(1'b1);
      `CHK("line_full", 8'h04, line_duty);
      `CHK("boost_full", 8'h04, boost_duty);
      locked <= 1'b1;
      tick(8);
      `CHK("unlock_locked", 1'b0, drv.sync_unlock_o);
      locked <= 1'b0;
      rnd = lfsr(rnd);
      hp = rnd;
      wr(8'h06, hp);
      `CHK("horizontal_phase_position_now", hp, geom.horizontal_phase_position);
      `CHK("still_run", 1'b1, drv.loops_en);
      wr(8'h0d, 8'h00);
      wait_loops(1'b0);
      tick(40);
      `CHK("line_down", 8'h00, line_duty);
      `CHK("vert_after_down", 1'b1, drv.vert_oe);
      wr(8'h0d, 8'h02);
      wait_loops(1'b1);
      trip_pulse();
      `CHK("protect", 1'b1, prot);
      `CHK("horizontal_phase_position_kept", hp, geom.horizontal_phase_position);
      `CHK("node_cleared", 1'b1, drv.soft_start_node_gnd);
      wr(8'h0d, 8'h02);
      wait_loops(1'b1);
      `CHK("protect_left", 1'b0, prot);
      trip_pulse();
      wr(8'h0d, 8'h01);
      `CHK("protect_standby", 1'b0, prot);
      `CHK("vert_standby2", 1'b0, drv.vert_oe);
      wr(8'h0d, 8'h00);
      wr(8'h0d, 8'h02);
      wait_loops(1'b1);
      s86 <= 1'b0;
      tick(60);
      `CHK("dip_line", 1'b0, drv.line_drive_oe);
      `CHK("dip_down", 8'h00, line_duty);
      s86 <= 1'b1;
      wait_loops(1'b1);
      s81 <= 1'b0;
      tick(8);
      `CHK("low_line", 1'b0, drv.line_drive_oe);
      `CHK("low_boost", 1'b0, drv.boost_drive_oe);
      s81 <= 1'b1;
      tick(12);
      `CHK("low_standby", 1'b0, drv.vert_oe);
      print_verdict();
   end
endmodule
bind dms_sequencer dms_sequencer_sva #(.RAMP_STEPS(RAMP_STEPS)) chk_u (
   .clk_i(clk_i), .srst_i(srst_i), .supply_8v1_i(supply_8v1_i),
   .supply_8v3_i(supply_8v3_i), .supply_8v6_i(supply_8v6_i), .loop_locked_i(loop_locked_i),
   .sda_oe_o(sda_oe_o), .drive_o(drive_o), .line_duty_o(line_duty_o),
   .boost_duty_o(boost_duty_o), .protect_mode_o(protect_mode_o), .geom_o(geom_o),
   .horizontal_moire_eff_o(horizontal_moire_eff_o), .vertical_moire_eff_o(vertical_moire_eff_o));
